// file: logic/coding_stream_pkg.sv
// Purpose: shared constants for output coding and streaming readout
// Assumes: 16-bit results, 200 MHz core clock
// Notes: register index doubles as the serial address
`default_nettype none
package coding_stream_pkg;
    localparam logic [5:0]  ADDR_CTRL       = 6'h01;
    localparam logic [5:0]  ADDR_DATA       = 6'h02;
    localparam logic [15:0] CTRL_RESET      = 16'h4000;
    localparam logic [15:0] CTRL_WMASK      = 16'h5800;
    localparam int          BIT_RSVD        = 15;
    localparam int          BIT_CODING      = 14;
    localparam int          BIT_REL_DEL     = 12;
    localparam int          BIT_STREAM      = 11;
    localparam int          CMD_RD_BIT      = 6;
    localparam logic [7:0]  EXIT_CMD        = 8'h42;
    localparam logic [15:0] OFFSET_FLIP     = 16'h8000;
    localparam logic [15:0] POS_FULL        = 16'h7fff;
    localparam logic [6:0]  SOFT_RST_LAST   = 7'h3f;
    localparam logic [15:0] ABORT_LEAD_MCLK = 16'h0004;
    localparam logic [4:0]  LEN_WORD        = 5'h10;
    localparam logic [4:0]  LEN_CRC         = 5'h18;
    localparam logic [4:0]  LAST_CMD_BIT    = 5'h07;
    localparam logic [4:0]  LAST_WR_BIT     = 5'h0f;
    localparam logic [7:0]  CRC_POLY        = 8'h07;
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          REL_SHORT_NS    = 10;
    localparam int          REL_LONG_NS     = 100;
    localparam logic [7:0]  REL_SHORT_CYC   =
        8'((REL_SHORT_NS / CLK_PERIOD_NS < 1) ? 1 : REL_SHORT_NS / CLK_PERIOD_NS);
    localparam logic [7:0]  REL_LONG_CYC    =
        8'((REL_LONG_NS / CLK_PERIOD_NS < 1) ? 1 : REL_LONG_NS / CLK_PERIOD_NS);
    typedef enum {PH_CMD, PH_WR, PH_RD, PH_STRM} phase_e;
endpackage : coding_stream_pkg
`default_nettype wire

// file: logic/sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: each bit is a level or a toggle
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= INIT;
            q      <= INIT;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : sync2
`default_nettype wire

// file: logic/crc8_word.sv
// Purpose: crc-8 of one word, msb first
// Assumes: zero seed
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module crc8_word
    import coding_stream_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic [W-1:0] d,
    output logic      [7:0]   crc
);
    logic [7:0] c;
    logic       fb;

    always_comb
    begin
        c  = 8'h00;
        fb = 1'b0;
        for (int i = W - 1; i >= 0; i--)
        begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        crc = c;
    end
endmodule : crc8_word
`default_nettype wire

// file: logic/coding_stream_core.sv
// Purpose: output coding, pin release delay and streaming readout of results
// Assumes: host clocks sclk in mode 3, command byte then data, msb first
// Notes: sclk logic reads result words held stable by the data-ready handshake
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - bit 14 picks output coding, resets set; coding is digital over a bipolar span
// - coding bit clear: straight binary, 0x0000 at zero, 0xffff at full scale
// - coding bit set: offset binary, 0x0000, 0x8000, 0xffff across the span
// - bit 12 picks pin release after last clock edge: 10 ns or 100 ns
// - bit 11 streams every new result with no command byte first
// - in streaming, clocks before data-ready low only feed the exit command and soft reset; each result read once
// - streamed read still running four modulator cycles before next result is dropped, ready high
// - exit command is taken without any checksum
// - streaming is off whenever the sample fifo is enabled
// - with crc active a checksum follows each streamed result
// - select pin disabled means 3-wire mode, where the release delay applies
module coding_stream_core
    import coding_stream_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sclk,
    input  wire logic        din,
    input  wire logic        cs_n,
    output logic             dout_rdy,
    output logic             dout_oe_n,
    input  wire logic [15:0] conv_raw,
    input  wire logic        conv_valid,
    input  wire logic        mclk_tick,
    input  wire logic [15:0] conv_len_mclk,
    input  wire logic        fifo_enable,
    input  wire logic        crc_enable,
    input  wire logic        select_pin_enable,
    output logic      [15:0] control_word,
    output logic             streaming
);
    // core domain
    logic [15:0] ctrl_r;
    logic [15:0] data_r;
    logic [7:0]  crc_r;
    logic        rdy_n_r;
    logic        cont_r;
    logic [15:0] mcnt_r;
    logic [7:0]  rel_cnt_r;
    logic [4:0]  tg_d_r;
    logic [15:0] coded;
    logic [7:0]  coded_crc;
    logic [7:0]  lk_s;
    logic        abort_pt;
    logic        accept;
    logic [4:0]  tg_ev;
    // link domain
    phase_e      ph_r;
    phase_e      ph_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;
    logic [5:0]  addr_r;
    logic [23:0] rd_w_r;
    logic [4:0]  len_r;
    logic [15:0] sh_r;
    logic [6:0]  ones_r;
    logic [15:0] wr_w_r;
    logic [4:0]  tg_r;
    logic        busy_r;
    logic        sdo_r;
    logic        lead_r;
    logic        rdy_lk;
    logic        rdy_lk_d_r;
    logic        link_clr;
    logic [7:0]  byte_w;
    logic [23:0] strm_w;
    logic [4:0]  strm_len;
    logic        strm_go;
    logic        last_bit;
    logic        abandon;
    logic        ev_srst;
    logic        ev_exit;
    logic        ev_wr;
    logic        ev_end;
    logic        ev_done;
    logic [4:0]  idx;

    assign control_word = ctrl_r;
    assign streaming    = cont_r;

    // coding of the raw two's complement result
    always_comb
    begin
        if (ctrl_r[BIT_CODING])
            coded = conv_raw ^ OFFSET_FLIP;
        else if (conv_raw[15])
            coded = 16'h0000;
        else if (conv_raw == POS_FULL)
            coded = 16'hffff;
        else
            coded = {conv_raw[14:0], 1'b0};
    end

    crc8_word #(.W(16)) u_crc (
        .d   (coded),
        .crc (coded_crc)
    );

    sync2 #(.W(8), .INIT(8'hc0)) u_sync_core (
        .clk (clk),
        .rst (rst),
        .d   ({cs_n, sdo_r, busy_r | lead_r, tg_r}),
        .q   (lk_s)
    );

    // toggles: wr, done, exit, soft reset, frame end
    assign tg_ev    = lk_s[4:0] ^ tg_d_r;
    assign accept   = conv_valid && !lk_s[5];
    assign abort_pt = mclk_tick && !conv_valid && (mcnt_r == ABORT_LEAD_MCLK + 16'h0001);

    always_ff @(posedge clk)
    begin
        if (rst)
            tg_d_r <= 5'h00;
        else
            tg_d_r <= lk_s[4:0];
    end

    always_ff @(posedge clk)
    begin
        if (rst || tg_ev[1])
            ctrl_r <= CTRL_RESET;
        else if (tg_ev[4])
            ctrl_r <= (ctrl_r & ~CTRL_WMASK) | (wr_w_r & CTRL_WMASK);
        else if (tg_ev[2])
            ctrl_r[BIT_STREAM] <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cont_r <= 1'b0;
        else
            cont_r <= ctrl_r[BIT_STREAM] && !fifo_enable;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            mcnt_r <= 16'h0000;
        else if (conv_valid)
            mcnt_r <= conv_len_mclk;
        else if (mclk_tick && mcnt_r != 16'h0000)
            mcnt_r <= mcnt_r - 16'h0001;
    end

    // a result landing mid-read is skipped, never mixed
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_r <= 16'h0000;
            crc_r  <= 8'h00;
        end
        else if (accept)
        begin
            data_r <= coded;
            crc_r  <= coded_crc;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdy_n_r <= 1'b1;
        else if (accept)
            rdy_n_r <= 1'b0;
        else if (abort_pt || tg_ev[3] || tg_ev[1])
            rdy_n_r <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rel_cnt_r <= 8'h00;
        else if (tg_ev[0] && !select_pin_enable)
            rel_cnt_r <= ctrl_r[BIT_REL_DEL] ? REL_LONG_CYC : REL_SHORT_CYC;
        else if (rel_cnt_r != 8'h00)
            rel_cnt_r <= rel_cnt_r - 8'h01;
    end

    // shared data and ready pin
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dout_rdy  <= 1'b1;
            dout_oe_n <= 1'b1;
        end
        else
        begin
            dout_rdy  <= (lk_s[5] || rel_cnt_r != 8'h00) ? lk_s[6] : rdy_n_r;
            dout_oe_n <= lk_s[7];
        end
    end

    // link domain
    assign link_clr = rst || (cs_n && select_pin_enable);

    sync2 #(.W(1), .INIT(1'b1)) u_sync_link (
        .clk (sclk),
        .rst (1'b0),
        .d   (rdy_n_r),
        .q   (rdy_lk)
    );

    always_comb
    begin
        byte_w   = {sh_r[6:0], din};
        strm_w   = {data_r, crc_r};
        strm_len = crc_enable ? LEN_CRC : LEN_WORD;
        strm_go  = (ph_r == PH_CMD) && cont_r && !rdy_n_r && cnt_r == 5'h00;
        last_bit = (cnt_r == len_r - 5'h01);
        abandon  = (ph_r == PH_STRM) && rdy_lk && !rdy_lk_d_r;
        ev_srst  = (ones_r == SOFT_RST_LAST) && din;
        ev_exit  = (ph_r == PH_CMD) && !strm_go && cnt_r == LAST_CMD_BIT
                   && cont_r && byte_w == EXIT_CMD;
        ev_wr    = (ph_r == PH_WR) && cnt_r == LAST_WR_BIT && addr_r == ADDR_CTRL;
        ev_end   = (ph_r == PH_RD || ph_r == PH_STRM) && last_bit && !abandon;
        ev_done  = ev_end && (ph_r == PH_STRM || addr_r == ADDR_DATA);
        idx      = 5'h17 - cnt_r;
    end

    always_comb
    begin
        ph_nxt  = ph_r;
        cnt_nxt = cnt_r + 5'h01;
        if (ev_srst)
        begin
            ph_nxt  = PH_CMD;
            cnt_nxt = 5'h00;
        end
        else
        begin
            case (ph_r)
                PH_CMD:
                begin
                    if (strm_go)
                        ph_nxt = PH_STRM;
                    else if (cnt_r == LAST_CMD_BIT)
                    begin
                        cnt_nxt = 5'h00;
                        if (!cont_r)
                            ph_nxt = byte_w[CMD_RD_BIT] ? PH_RD : PH_WR;
                    end
                end
                PH_WR:
                begin
                    if (cnt_r == LAST_WR_BIT)
                    begin
                        ph_nxt  = PH_CMD;
                        cnt_nxt = 5'h00;
                    end
                end
                PH_RD, PH_STRM:
                begin
                    if (last_bit || abandon)
                    begin
                        ph_nxt  = PH_CMD;
                        cnt_nxt = 5'h00;
                    end
                end
                default:
                begin
                    ph_nxt  = PH_CMD;
                    cnt_nxt = 5'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sclk or posedge link_clr)
    begin
        if (link_clr)
        begin
            ph_r   <= PH_CMD;
            cnt_r  <= 5'h00;
            busy_r <= 1'b0;
        end
        else
        begin
            ph_r   <= ph_nxt;
            cnt_r  <= cnt_nxt;
            busy_r <= (ph_nxt == PH_RD) || (ph_nxt == PH_STRM);
        end
    end

    always_ff @(posedge sclk or posedge link_clr)
    begin
        if (link_clr)
        begin
            sh_r   <= 16'h0000;
            ones_r <= 7'h00;
            addr_r <= 6'h00;
            rd_w_r <= 24'h000000;
            len_r  <= LEN_WORD;
        end
        else
        begin
            sh_r   <= {sh_r[14:0], din};
            ones_r <= (din && !ev_srst) ? ones_r + 7'h01 : 7'h00;
            if (strm_go)
                len_r <= strm_len;
            else if (ph_r == PH_CMD && cnt_r == LAST_CMD_BIT && !cont_r)
            begin
                addr_r <= byte_w[5:0];
                len_r  <= LEN_WORD;
                rd_w_r <= 24'h000000;
                if (byte_w[5:0] == ADDR_CTRL)
                    rd_w_r <= {ctrl_r, 8'h00};
                else if (byte_w[5:0] == ADDR_DATA)
                begin
                    rd_w_r <= strm_w;
                    len_r  <= strm_len;
                end
            end
        end
    end

    // toggles survive select-pin resets so no false events reach the core
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            wr_w_r     <= 16'h0000;
            tg_r       <= 5'h00;
            rdy_lk_d_r <= 1'b1;
        end
        else
        begin
            rdy_lk_d_r <= rdy_lk;
            if (ev_wr)
                wr_w_r <= {sh_r[14:0], din};
            tg_r <= tg_r ^ {ev_wr, ev_done, ev_exit, ev_srst, ev_end};
        end
    end

    always_ff @(negedge sclk or posedge link_clr)
    begin
        if (link_clr)
            sdo_r <= 1'b1;
        else if (ph_r == PH_RD)
            sdo_r <= rd_w_r[idx];
        else if (ph_r == PH_STRM || strm_go)
            sdo_r <= strm_w[idx];
        else
            sdo_r <= 1'b1;
    end

    // first streamed bit leaves before busy is set; pin must show it, not ready
    always_ff @(negedge sclk or posedge link_clr)
    begin
        if (link_clr)
            lead_r <= 1'b0;
        else
            lead_r <= strm_go;
    end

    chk_reset_ctrl: assert property (@(posedge clk) $past(rst) |-> ctrl_r == CTRL_RESET)
        else $error("control register not at reset value");
    chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst) !ctrl_r[BIT_RSVD])
        else $error("reserved bit set");
    chk_offset_code: assert property (@(posedge clk) disable iff (rst)
        accept && ctrl_r[BIT_CODING] |=> data_r == ($past(conv_raw) ^ OFFSET_FLIP))
        else $error("offset binary code wrong");
    chk_straight_neg: assert property (@(posedge clk) disable iff (rst)
        accept && !ctrl_r[BIT_CODING] && conv_raw[15] |=> data_r == 16'h0000)
        else $error("negative input not clamped to zero");
    chk_abort_ready: assert property (@(posedge clk) disable iff (rst)
        abort_pt |=> rdy_n_r ##1 $stable(data_r))
        else $error("ready not raised at abort point");
    chk_new_ready: assert property (@(posedge clk) disable iff (rst)
        accept |=> !rdy_n_r && data_r == $past(coded))
        else $error("new result not flagged ready");
    chk_release_short: assert property (@(posedge clk) disable iff (rst)
        tg_ev[0] && !select_pin_enable && !ctrl_r[BIT_REL_DEL]
        |=> (rel_cnt_r != 8'h00) [*2] ##1 rel_cnt_r == 8'h00)
        else $error("short release time wrong");
    chk_fifo_blocks: assert property (@(posedge clk) disable iff (rst)
        fifo_enable |=> !cont_r)
        else $error("streaming while fifo enabled");
    chk_read_once: assert property (@(posedge clk) disable iff (rst)
        tg_ev[3] && !accept |=> rdy_n_r)
        else $error("ready still low after result read");
endmodule : coding_stream_core
`default_nettype wire

// file: dv/host_model.sv
// Purpose: host controller model on the far side of the serial link
// Assumes: mode 3, msb first, 80 ns link clock
// Notes: sclk stands still between frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic      sclk,
    output logic      din,
    output logic      cs_n,
    input  wire logic dout_rdy
);
    logic [63:0] rx;

    initial
    begin
        sclk = 1'b1;
        din  = 1'b1;
        cs_n = 1'b1;
        rx   = '0;
    end

    // one frame of n bits; hold keeps the select low (3-wire)
    task automatic xfer(input logic [63:0] tx, input int n, input bit hold);
        #80;
        cs_n = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b0;
            din  = tx[i];
            #40;
            sclk = 1'b1;
            rx   = {rx[62:0], dout_rdy};
            #40;
        end
        din = ~din;
        if (!hold)
            cs_n = 1'b1;
    endtask : xfer

    // waits for ready low, then gives exactly n clocks
    task automatic stream(input int n);
        bit ok;
        ok = 1'b0;
        for (int i = 0; i < 2000 && !ok; i++)
            #5 ok = (dout_rdy === 1'b0);
        rx = '1;
        if (ok)
            xfer('0, n, 1'b0);
    endtask : stream
endmodule : host_model
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench for coding and streaming readout
// Assumes: 200 MHz core clock, host model on the link
// Notes: expected words come from a queue model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rst, sclk, din, cs_n, dout_rdy, dout_oe_n;
    logic [15:0] conv_raw, conv_len_mclk, control_word, ctrl_m;
    logic        conv_valid, mclk_tick, fifo_enable, crc_enable;
    logic        select_pin_enable, streaming;
    logic [15:0] exp_w;
    logic [15:0] edge_v [4] = '{16'h8000, 16'h0000, 16'h7fff, 16'hffff};
    logic [15:0] exp_q [$];
    int          err_total, cmp_count, cyc;
    logic [3:0]  tick_cnt;

    coding_stream_core u_dut (
        .clk(clk), .rst(rst), .sclk(sclk), .din(din), .cs_n(cs_n),
        .dout_rdy(dout_rdy), .dout_oe_n(dout_oe_n), .conv_raw(conv_raw),
        .conv_valid(conv_valid), .mclk_tick(mclk_tick),
        .conv_len_mclk(conv_len_mclk), .fifo_enable(fifo_enable),
        .crc_enable(crc_enable), .select_pin_enable(select_pin_enable),
        .control_word(control_word), .streaming(streaming)
    );

    host_model u_host (.sclk(sclk), .din(din), .cs_n(cs_n), .dout_rdy(dout_rdy));

    initial
    begin
        clk = 1'b0;
        forever
            #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        tick_cnt  <= tick_cnt + 4'h1;
        mclk_tick <= (tick_cnt[2:0] == 3'h7);
        cyc       <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            end_sim();
        end
    end

    function automatic logic [15:0] code(input logic [15:0] raw, input bit off);
        int v;
        v = int'($signed(raw));
        if (off)
            return raw ^ 16'h8000;
        if (v < 0)
            return 16'h0000;
        if (v == 32767)
            return 16'hffff;
        return 16'(v * 2);
    endfunction : code

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask : check

    task automatic clks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : clks

    task automatic wr(input logic [15:0] v);
        u_host.xfer({40'h0, 8'h01, v}, 24, !select_pin_enable);
        ctrl_m = v & 16'h5800;
        clks(6);
        check("control_word", ctrl_m, control_word);
    endtask : wr

    task automatic rd(input logic [7:0] cmd);
        u_host.xfer({40'h0, cmd, 16'h0}, 24, !select_pin_enable);
    endtask : rd

    task automatic conv(input logic [15:0] raw, input logic [15:0] len);
        clks(1);
        conv_raw      = raw;
        conv_len_mclk = len;
        conv_valid    = 1'b1;
        clks(1);
        conv_valid = 1'b0;
        exp_q.push_back(code(raw, ctrl_m[14]));
    endtask : conv

    task automatic end_sim;
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        rst = 1'b1;
        conv_raw = 16'h0;
        conv_valid = 1'b0;
        mclk_tick = 1'b0;
        conv_len_mclk = 16'hffff;
        fifo_enable = 1'b0;
        crc_enable = 1'b0;
        select_pin_enable = 1'b0;
        err_total = 0;
        cmp_count = 0;
        cyc = 0;
        tick_cnt = 4'h0;
        ctrl_m = 16'h4000;
        void'($urandom(66928));
        clks(6);
        rst = 1'b0;
        clks(3);
        check("reset control", 16'h4000, control_word);
        check("reset idle", 3'b011, {streaming, dout_rdy, dout_oe_n});
        // 3-wire: release delay short then long
        for (int d = 0; d < 2; d++)
        begin
            wr(d ? 16'h5000 : 16'h4000);
            rd(8'h41);
            check("release early", d ? 1'b0 : 1'b1, dout_rdy);
            check("pin enabled", 1'b0, dout_oe_n);
            clks(20);
            check("release late", 1'b1, dout_rdy);
            check("ctrl read", ctrl_m, u_host.rx[15:0]);
        end
        select_pin_enable = 1'b1;
        wr(16'hb7ff);
        check("pin released", 1'b1, dout_oe_n);
        // both codings over edge and random values
        for (int c = 0; c < 2; c++)
        begin
            wr(c ? 16'h4000 : 16'h0000);
            for (int k = 0; k < 6; k++)
            begin
                conv((k < 4) ? edge_v[k] : 16'($urandom), 16'hffff);
                rd(8'h42);
                exp_w = exp_q.pop_front();
                check("coded data", exp_w, u_host.rx[15:0]);
            end
        end
        // streaming with checksum
        crc_enable = 1'b1;
        wr(16'h4800);
        check("streaming on", 1'b1, streaming);
        for (int k = 0; k < 3; k++)
        begin
            u_host.xfer('0, 16, 1'b0);
            check("idle ones", 16'hffff, u_host.rx[15:0]);
            conv(16'($urandom), 16'hffff);
            u_host.stream(24);
            exp_w = exp_q.pop_front();
            check("stream word", {exp_w, crc8(exp_w)}, u_host.rx[23:0]);
        end
        // read overtaken by the next result
        conv(16'h8000, 16'h0008);
        u_host.stream(24);
        exp_w = exp_q.pop_front();
        check("abort crc", 8'hff, u_host.rx[7:0]);
        check("abort ready", 1'b1, dout_rdy);
        fifo_enable = 1'b1;
        clks(3);
        check("fifo stops", 1'b0, streaming);
        fifo_enable = 1'b0;
        clks(3);
        check("fifo off", 1'b1, streaming);
        u_host.xfer(64'h42, 8, 1'b0);
        clks(6);
        check("exit cmd", 1'b0, streaming);
        wr(16'h4800);
        u_host.xfer('1, 64, 1'b0);
        clks(6);
        check("soft reset", 17'h04000, {streaming, control_word});
        end_sim();
    end
endmodule : testbench
`default_nettype wire
